// [hdl/xfe_top.sv]
// Interrupt or software activated transfer engine with AXI4-Lite registers
//
// Overview of operation
// - Start on enabled request or soft vector write
// - Read descriptor, move data, write descriptor back
// - Each request goes to CPU or engine
// - CPU mask and priorities ignored for engine
// - Software first, then lowest vector number wins
// - Soft vector address is 0x0400 plus field<<1
// - Hardware vector address is 0x0400 plus 2*vector
// - Vector word gives low 16 descriptor address bits
// - Descriptor order: mode A, source, mode B, dest, counts
// - Normal, repeat, block; pointers inc, dec, fixed
// - Source and destination pointers are 24 bits
// - Unit is byte or 16-bit word
// - Optionally pass interrupt to CPU each transfer
// - Otherwise interrupt CPU when count exhausted
// - Chain flag runs further descriptors in one activation
// - Vector read, six descriptor accesses, three internal states
// - Time is sum of all accesses and internal states
// - Registers reachable after reset; stop mode holds off new activations
// - Bus obtained from shared arbiter by request/grant
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "xfe_regs.svh"

module xfe_top
	import xfe_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [7:0]   s_axi_awaddr_i,
	input  wire logic         s_axi_awvalid_i,
	output logic              s_axi_awready_o,
	input  wire logic [31:0]  s_axi_wdata_i,
	input  wire logic [3:0]   s_axi_wstrb_i,
	input  wire logic         s_axi_wvalid_i,
	output logic              s_axi_wready_o,
	output logic [1:0]        s_axi_bresp_o,
	output logic              s_axi_bvalid_o,
	input  wire logic         s_axi_bready_i,
	input  wire logic [7:0]   s_axi_araddr_i,
	input  wire logic         s_axi_arvalid_i,
	output logic              s_axi_arready_o,
	output logic [31:0]       s_axi_rdata_o,
	output logic [1:0]        s_axi_rresp_o,
	output logic              s_axi_rvalid_o,
	input  wire logic         s_axi_rready_i,
	input  wire logic [127:0] irq_req_i,
	output logic [127:0]      cpu_irq_o,
	output logic              soft_irq_o,
	output logic              src_clr_o,
	output logic [6:0]        src_clr_vec_o,
	output logic              bus_req_o,
	input  wire logic         bus_gnt_i,
	output logic              mem_valid_o,
	output logic              mem_write_o,
	output logic [23:0]       mem_addr_o,
	output logic [1:0]        mem_size_o,
	output logic [31:0]       mem_wdata_o,
	input  wire logic         mem_ack_i,
	input  wire logic [31:0]  mem_rdata_i
);

	function automatic logic [23:0] step_ptr(input logic [23:0] p, input logic [1:0] m,
			input logic sz);
		logic [23:0] d;
		d = sz ? 24'h000002 : 24'h000001;
		case (m)
			2'b10:   step_ptr = p + d;
			2'b11:   step_ptr = p - d;
			default: step_ptr = p;
		endcase
	endfunction

	function automatic logic [31:0] pick_reg(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			pick_reg[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	xfe_state_type state_ff;
	logic [7:0]   aw_addr_ff;
	logic         aw_held_ff;
	logic [31:0]  w_data_ff;
	logic [3:0]   w_strb_ff;
	logic         w_held_ff;
	logic         stop_ff;
	logic         soft_go_ff;
	logic [6:0]   soft_vec_ff;
	logic [127:0] en_ff;
	logic [127:0] pass_ff;
	logic         busy_ff;
	logic         cur_soft_ff;
	logic [6:0]   cur_vec_ff;
	logic [23:0]  desc_ff;
	logic [7:0]   mra_ff;
	logic [7:0]   mrb_ff;
	logic [23:0]  sar_ff;
	logic [23:0]  dar_ff;
	logic [15:0]  cra_ff;
	logic [15:0]  crb_ff;
	logic [23:0]  blk_start_ff;
	logic [7:0]   unit_left_ff;
	logic [31:0]  data_ff;
	logic [1:0]   iop_ff;
	logic         end_cnt_ff;
	logic         fire_cpu_ff;
	logic         go_on_ff;

	logic         wr_fire;
	logic         pend_hw;
	logic [6:0]   pend_vec;
	logic [127:0] eligible;
	logic         start;
	logic         acc_done;
	xfe_mode_type mode;
	logic         sz;

	assign mode     = xfe_mode_type'(mra_ff[`XFE_MRA_MD_HI -: 2]);
	assign sz       = mra_ff[`XFE_MRA_SZ_BIT];
	assign wr_fire  = aw_held_ff && w_held_ff && !s_axi_bvalid_o;
	assign acc_done = mem_valid_o && mem_ack_i;
	// No CPU level or priority enters here; a hand-over keeps it from rerunning
	assign eligible = irq_req_i & en_ff & ~pass_ff;

	always_comb begin
		pend_hw  = 1'b0;
		pend_vec = 7'h00;
		for (int i = 127; i >= 0; i--) begin
			if (eligible[i]) begin
				pend_hw  = 1'b1;
				pend_vec = 7'(i);
			end
		end
	end

	assign start = (state_ff == XFE_IDLE) && !stop_ff && (soft_go_ff || pend_hw);

	// AXI write channels, taken in either order
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_held_ff      <= 1'b0;
			aw_addr_ff      <= 8'h00;
			s_axi_awready_o <= 1'b1;
			w_held_ff       <= 1'b0;
			w_data_ff       <= 32'h0000_0000;
			w_strb_ff       <= 4'h0;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= 2'b00;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held_ff      <= 1'b1;
				aw_addr_ff      <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held_ff      <= 1'b1;
				w_data_ff      <= s_axi_wdata_i;
				w_strb_ff      <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				case (aw_addr_ff)
					`XFE_SOFT_VEC_OFS, `XFE_CTRL_OFS, `XFE_STATUS_OFS, `XFE_EN0_OFS,
					`XFE_EN1_OFS, `XFE_EN2_OFS, `XFE_EN3_OFS: s_axi_bresp_o <= 2'b00;
					default: s_axi_bresp_o <= 2'b11;
				endcase
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				aw_held_ff      <= 1'b0;
				w_held_ff       <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// AXI read channel
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= 2'b00;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= 2'b00;
			case (s_axi_araddr_i)
				`XFE_SOFT_VEC_OFS: s_axi_rdata_o <= {24'h000000, soft_go_ff, soft_vec_ff};
				`XFE_CTRL_OFS:     s_axi_rdata_o <= {31'h00000000, stop_ff};
				`XFE_STATUS_OFS:   s_axi_rdata_o <= {16'h0000, cur_vec_ff, cur_soft_ff,
						state_ff, 3'h0, busy_ff};
				`XFE_EN0_OFS:      s_axi_rdata_o <= en_ff[31:0];
				`XFE_EN1_OFS:      s_axi_rdata_o <= en_ff[63:32];
				`XFE_EN2_OFS:      s_axi_rdata_o <= en_ff[95:64];
				`XFE_EN3_OFS:      s_axi_rdata_o <= en_ff[127:96];
				default: begin
					s_axi_rdata_o <= 32'h0000_0000;
					s_axi_rresp_o <= 2'b11;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// Control register: module stop, reachable from reset onward
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stop_ff <= 1'(`XFE_CTRL_RESET);
		end else if (wr_fire && aw_addr_ff == `XFE_CTRL_OFS && w_strb_ff[0]) begin
			stop_ff <= w_data_ff[`XFE_CTRL_STOP_BIT];
		end
	end

	// Soft activation: a new write beats the clear of the old one
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_go_ff  <= 1'b0;
			soft_vec_ff <= 7'h00;
		end else if (wr_fire && aw_addr_ff == `XFE_SOFT_VEC_OFS && w_strb_ff[0]) begin
			soft_go_ff  <= w_data_ff[`XFE_SOFT_GO_BIT];
			soft_vec_ff <= w_data_ff[6:0];
		end else if (start && soft_go_ff) begin
			soft_go_ff <= 1'b0;
		end
	end

	// Engine routing enables; count end hands the source back to the CPU
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_ff <= {4{`XFE_EN_RESET}};
		end else if (wr_fire && aw_addr_ff[7:4] == 4'h1) begin
			case (aw_addr_ff[3:2])
				2'd0: en_ff[31:0]   <= pick_reg(en_ff[31:0], w_data_ff, w_strb_ff);
				2'd1: en_ff[63:32]  <= pick_reg(en_ff[63:32], w_data_ff, w_strb_ff);
				2'd2: en_ff[95:64]  <= pick_reg(en_ff[95:64], w_data_ff, w_strb_ff);
				default: en_ff[127:96] <= pick_reg(en_ff[127:96], w_data_ff, w_strb_ff);
			endcase
		end else if (state_ff == XFE_FINISH && !cur_soft_ff && end_cnt_ff) begin
			en_ff[cur_vec_ff] <= 1'b0;
		end
	end

	// Requests pass to the CPU when not routed to the engine or when handed over
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pass_ff   <= 128'h0;
			cpu_irq_o <= 128'h0;
		end else begin
			for (int i = 0; i < 128; i++) begin
				if (state_ff == XFE_FINISH && !cur_soft_ff && fire_cpu_ff &&
						cur_vec_ff == 7'(i)) begin
					pass_ff[i] <= 1'b1;
				end else if (!irq_req_i[i]) begin
					pass_ff[i] <= 1'b0;
				end
			end
			cpu_irq_o <= irq_req_i & (~en_ff | pass_ff);
		end
	end

	// Soft completion flag, cleared by the next soft vector write
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_irq_o <= 1'b0;
		end else if (state_ff == XFE_FINISH && cur_soft_ff && fire_cpu_ff) begin
			soft_irq_o <= 1'b1;
		end else if (wr_fire && aw_addr_ff == `XFE_SOFT_VEC_OFS) begin
			soft_irq_o <= 1'b0;
		end
	end

	// Source clear pulse when the engine consumed the request itself
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_clr_o     <= 1'b0;
			src_clr_vec_o <= 7'h00;
		end else begin
			src_clr_o     <= state_ff == XFE_FINISH && !cur_soft_ff && !fire_cpu_ff;
			src_clr_vec_o <= cur_vec_ff;
		end
	end

	// Bus ownership spans the whole activation
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_req_o <= 1'b0;
			busy_ff   <= 1'b0;
		end else if (start) begin
			bus_req_o <= 1'b1;
			busy_ff   <= 1'b1;
		end else if (state_ff == XFE_WB2 && acc_done && !go_on_ff) begin
			bus_req_o <= 1'b0;
			busy_ff   <= 1'b0;
		end
	end

	// Memory master: one access per state, issued only under grant
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mem_valid_o <= 1'b0;
			mem_write_o <= 1'b0;
			mem_addr_o  <= 24'h000000;
			mem_size_o  <= `XFE_SZ_LONG;
			mem_wdata_o <= 32'h0000_0000;
		end else if (acc_done) begin
			mem_valid_o <= 1'b0;
		end else if (!mem_valid_o && bus_gnt_i && bus_req_o) begin
			mem_valid_o <= state_ff != XFE_INTOP && state_ff != XFE_FINISH &&
					state_ff != XFE_IDLE;
			mem_write_o <= state_ff == XFE_DATWR || state_ff == XFE_WB0 ||
					state_ff == XFE_WB1 || state_ff == XFE_WB2;
			mem_size_o  <= `XFE_SZ_LONG;
			case (state_ff)
				XFE_VREAD: begin
					mem_addr_o <= {8'h00, cur_vec_addr()};
					mem_size_o <= `XFE_SZ_WORD;
				end
				XFE_DRD0: mem_addr_o <= desc_ff;
				XFE_DRD1: mem_addr_o <= desc_ff + 24'h000004;
				XFE_DRD2: mem_addr_o <= desc_ff + 24'h000008;
				XFE_DATRD: begin
					mem_addr_o <= sar_ff;
					mem_size_o <= sz ? `XFE_SZ_WORD : `XFE_SZ_BYTE;
				end
				XFE_DATWR: begin
					mem_addr_o  <= dar_ff;
					mem_size_o  <= sz ? `XFE_SZ_WORD : `XFE_SZ_BYTE;
					mem_wdata_o <= sz ? {16'h0000, data_ff[15:0]} : {24'h000000, data_ff[7:0]};
				end
				XFE_WB0: begin
					mem_addr_o  <= desc_ff;
					mem_wdata_o <= {mra_ff, sar_ff};
				end
				XFE_WB1: begin
					mem_addr_o  <= desc_ff + 24'h000004;
					mem_wdata_o <= {mrb_ff, dar_ff};
				end
				XFE_WB2: begin
					mem_addr_o  <= desc_ff + 24'h000008;
					mem_wdata_o <= {cra_ff, crb_ff};
				end
				default: mem_addr_o <= mem_addr_o;
			endcase
		end
	end

	function automatic logic [15:0] cur_vec_addr();
		cur_vec_addr = `XFE_VEC_BASE + {8'h00, cur_vec_ff, 1'b0};
	endfunction

	// Sequencer
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff     <= XFE_IDLE;
			cur_soft_ff  <= 1'b0;
			cur_vec_ff   <= 7'h00;
			desc_ff      <= 24'h000000;
			mra_ff       <= 8'h00;
			mrb_ff       <= 8'h00;
			sar_ff       <= 24'h000000;
			dar_ff       <= 24'h000000;
			cra_ff       <= 16'h0000;
			crb_ff       <= 16'h0000;
			blk_start_ff <= 24'h000000;
			unit_left_ff <= 8'h00;
			data_ff      <= 32'h0000_0000;
			iop_ff       <= 2'd0;
			end_cnt_ff   <= 1'b0;
			fire_cpu_ff  <= 1'b0;
			go_on_ff     <= 1'b0;
		end else begin
			case (state_ff)
				XFE_IDLE: begin
					if (start) begin
						state_ff    <= XFE_VREAD;
						cur_soft_ff <= soft_go_ff;
						cur_vec_ff  <= soft_go_ff ? soft_vec_ff : pend_vec;
						end_cnt_ff  <= 1'b0;
						fire_cpu_ff <= 1'b0;
					end
				end
				XFE_VREAD: begin
					if (acc_done) begin
						desc_ff  <= {`XFE_RAM_PAGE, mem_rdata_i[15:0]};
						state_ff <= XFE_DRD0;
					end
				end
				XFE_DRD0: begin
					if (acc_done) begin
						{mra_ff, sar_ff} <= mem_rdata_i;
						state_ff         <= XFE_DRD1;
					end
				end
				XFE_DRD1: begin
					if (acc_done) begin
						{mrb_ff, dar_ff} <= mem_rdata_i;
						state_ff         <= XFE_DRD2;
					end
				end
				XFE_DRD2: begin
					if (acc_done) begin
						{cra_ff, crb_ff} <= mem_rdata_i;
						unit_left_ff     <= mode == XFE_MODE_BLOCK ? mem_rdata_i[23:16] : 8'h01;
						blk_start_ff     <= mra_ff[`XFE_MRA_DTS_BIT] ? sar_ff : dar_ff;
						iop_ff           <= 2'd0;
						state_ff         <= XFE_INTOP;
					end
				end
				XFE_INTOP: begin
					iop_ff <= iop_ff + 2'd1;
					if (iop_ff == `XFE_INT_OPS - 2'd1) begin
						state_ff <= XFE_DATRD;
					end
				end
				XFE_DATRD: begin
					if (acc_done) begin
						data_ff  <= mem_rdata_i;
						state_ff <= XFE_DATWR;
					end
				end
				XFE_DATWR: begin
					if (acc_done) begin
						sar_ff       <= step_ptr(sar_ff, mra_ff[`XFE_MRA_SM_HI -: 2], sz);
						dar_ff       <= step_ptr(dar_ff, mra_ff[`XFE_MRA_DM_HI -: 2], sz);
						unit_left_ff <= unit_left_ff - 8'h01;
						if (unit_left_ff != 8'h01) begin
							state_ff <= XFE_DATRD;
						end else begin
							state_ff <= XFE_WB0;
							case (mode)
								XFE_MODE_REPEAT: begin
									cra_ff[7:0] <= cra_ff[7:0] == 8'h01 ? cra_ff[15:8] :
											cra_ff[7:0] - 8'h01;
								end
								XFE_MODE_BLOCK: begin
									crb_ff <= crb_ff - 16'h0001;
									end_cnt_ff <= crb_ff == 16'h0001;
									if (mra_ff[`XFE_MRA_DTS_BIT]) begin
										sar_ff <= blk_start_ff;
									end else begin
										dar_ff <= blk_start_ff;
									end
								end
								default: begin
									cra_ff     <= cra_ff - 16'h0001;
									end_cnt_ff <= cra_ff == 16'h0001;
								end
							endcase
						end
					end
				end
				XFE_WB0: begin
					fire_cpu_ff <= fire_cpu_ff | end_cnt_ff | mrb_ff[`XFE_MRB_DISEL_BIT];
					go_on_ff    <= mrb_ff[`XFE_MRB_CHAIN_BIT];
					if (acc_done) begin
						state_ff <= XFE_WB1;
					end
				end
				XFE_WB1: begin
					if (acc_done) begin
						state_ff <= XFE_WB2;
					end
				end
				XFE_WB2: begin
					if (acc_done) begin
						if (go_on_ff) begin
							desc_ff  <= desc_ff + `XFE_DESC_STEP;
							state_ff <= XFE_DRD0;
						end else begin
							state_ff <= XFE_FINISH;
						end
					end
				end
				XFE_FINISH: state_ff <= XFE_IDLE;
				default: state_ff <= XFE_IDLE;
			endcase
		end
	end

endmodule

// [hdl/xfe_regs.svh]
// Register offsets, field positions, reset values and timing counts of the transfer engine
`ifndef XFE_REGS_SVH
`define XFE_REGS_SVH

`define XFE_SOFT_VEC_OFS    8'h00
`define XFE_CTRL_OFS        8'h04
`define XFE_STATUS_OFS      8'h08
`define XFE_EN0_OFS         8'h10
`define XFE_EN1_OFS         8'h14
`define XFE_EN2_OFS         8'h18
`define XFE_EN3_OFS         8'h1C

`define XFE_SOFT_GO_BIT     7
`define XFE_CTRL_STOP_BIT   0
`define XFE_CTRL_RESET      32'h0000_0000
`define XFE_EN_RESET        32'h0000_0000

`define XFE_VEC_BASE        16'h0400
`define XFE_RAM_PAGE        8'hFF
`define XFE_DESC_STEP       24'h00000C

`define XFE_MRA_SM_HI       7
`define XFE_MRA_DM_HI       5
`define XFE_MRA_MD_HI       3
`define XFE_MRA_DTS_BIT     1
`define XFE_MRA_SZ_BIT      0
`define XFE_MRB_CHAIN_BIT   7
`define XFE_MRB_DISEL_BIT   6

`define XFE_INT_OPS         2'd3
`define XFE_SZ_BYTE         2'b00
`define XFE_SZ_WORD         2'b01
`define XFE_SZ_LONG         2'b10

`endif

// [hdl/xfe_pkg.sv]
// Types shared by the transfer engine
package xfe_pkg;

	typedef enum logic [3:0] {
		XFE_IDLE,
		XFE_VREAD,
		XFE_DRD0,
		XFE_DRD1,
		XFE_DRD2,
		XFE_INTOP,
		XFE_DATRD,
		XFE_DATWR,
		XFE_WB0,
		XFE_WB1,
		XFE_WB2,
		XFE_FINISH
	} xfe_state_type;

	typedef enum logic [1:0] {
		XFE_MODE_NORMAL = 2'b00,
		XFE_MODE_REPEAT = 2'b01,
		XFE_MODE_BLOCK  = 2'b10
	} xfe_mode_type;

endpackage

// [tb/xfe_assertions.sv]
// Concurrent checks on the transfer engine ports
`timescale 1ns/1ns
module xfe_assertions (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         s_axi_awready_o,
	input  wire logic         s_axi_wready_o,
	input  wire logic [1:0]   s_axi_bresp_o,
	input  wire logic         s_axi_bvalid_o,
	input  wire logic         s_axi_bready_i,
	input  wire logic         s_axi_arvalid_i,
	input  wire logic         s_axi_arready_o,
	input  wire logic [31:0]  s_axi_rdata_o,
	input  wire logic         s_axi_rvalid_o,
	input  wire logic         s_axi_rready_i,
	input  wire logic [127:0] irq_req_i,
	input  wire logic [127:0] cpu_irq_o,
	input  wire logic         src_clr_o,
	input  wire logic         bus_req_o,
	input  wire logic         bus_gnt_i,
	input  wire logic         mem_valid_o,
	input  wire logic         mem_write_o,
	input  wire logic [23:0]  mem_addr_o,
	input  wire logic [1:0]   mem_size_o,
	input  wire logic         mem_ack_i
);
	logic pend_ff;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// Set while idle, so only the first access of an activation is checked
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			pend_ff <= 1'b1;
		else if (mem_valid_o)
			pend_ff <= 1'b0;
		else if (!bus_req_o)
			pend_ff <= 1'b1;
	end
	a_b_after_both: assert property (
		$rose(s_axi_bvalid_o) |-> $past(!s_axi_awready_o && !s_axi_wready_o))
		else $error("write answered before both halves taken");
	a_b_holds: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	a_r_answer: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read data not one edge after address");
	a_r_holds: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data changed before taken");
	a_mem_granted: assert property (
		$rose(mem_valid_o) |-> bus_req_o && $past(bus_gnt_i))
		else $error("access started without grant");
	a_mem_stable: assert property (
		mem_valid_o && !mem_ack_i |=> mem_valid_o && $stable(mem_addr_o) && $stable(mem_write_o))
		else $error("access changed before acknowledge");
	a_vec_first: assert property (
		mem_valid_o && pend_ff |-> !mem_write_o && mem_size_o == 2'h1
			&& mem_addr_o[23:8] == 16'h0004 && !mem_addr_o[0])
		else $error("activation did not start with a vector read");
	a_req_held: assert property (
		$fell(bus_req_o) |-> $past(mem_ack_i && mem_write_o) && $past(mem_addr_o[23:16]) == 8'hFF)
		else $error("bus released before final write-back");
	a_clr_pulse: assert property (
		src_clr_o |=> !src_clr_o)
		else $error("consume pulse longer than one cycle");
	a_cpu_route: assert property (
		(cpu_irq_o & ~$past(irq_req_i)) == 128'h0)
		else $error("cpu interrupt without request");
endmodule

bind xfe_top xfe_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.irq_req_i(irq_req_i), .cpu_irq_o(cpu_irq_o), .src_clr_o(src_clr_o),
	.bus_req_o(bus_req_o), .bus_gnt_i(bus_gnt_i), .mem_valid_o(mem_valid_o),
	.mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o), .mem_size_o(mem_size_o),
	.mem_ack_i(mem_ack_i));

// [tb/xfe_mem_model.sv]
// Memory and bus arbiter on the far side of the transfer engine
`timescale 1ns/1ns
module xfe_mem_model (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        bus_req_i,
	output logic             bus_gnt_o,
	input  wire logic        mem_valid_i,
	input  wire logic        mem_write_i,
	input  wire logic [23:0] mem_addr_i,
	input  wire logic [1:0]  mem_size_i,
	input  wire logic [31:0] mem_wdata_i,
	output logic             mem_ack_o,
	output logic [31:0]      mem_rdata_o
);
	logic [7:0] mem [int];
	int         wait_cyc = 0;
	int         cnt_ff;
	int         acks = 0;
	function automatic logic [31:0] rd(input logic [23:0] a, input int n);
		rd = 32'h0;
		for (int i = 0; i < n; i++)
			rd = {rd[23:0], mem.exists(a + i) ? mem[a + i] : 8'h00};
	endfunction
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_gnt_o <= 1'b0;
			mem_ack_o <= 1'b0;
			mem_rdata_o <= 32'h0;
			cnt_ff <= 0;
		end else begin
			bus_gnt_o <= bus_req_i;
			mem_ack_o <= 1'b0;
			// Idle data toggles so a stale value is never mistaken for a read
			mem_rdata_o <= ~mem_rdata_o;
			if (mem_valid_i && bus_gnt_o && !mem_ack_o) begin
				if (cnt_ff < wait_cyc)
					cnt_ff <= cnt_ff + 1;
				else begin
					cnt_ff <= 0;
					mem_ack_o <= 1'b1;
					acks++;
					if (mem_write_i)
						for (int i = 0; i < (1 << mem_size_i); i++)
							mem[mem_addr_i + i] = mem_wdata_i[8 * ((1 << mem_size_i) - 1 - i) +: 8];
					else
						mem_rdata_o <= rd(mem_addr_i, 1 << mem_size_i);
				end
			end
		end
	end
endmodule

// [tb/xfe_top_tb.sv]
// Self-checking bench for the transfer engine
`timescale 1ns/1ns
`include "xfe_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module xfe_top_tb;
	logic         clk_i = 1'b0;
	logic         resetn_i, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, mem_wdata, mem_rdata;
	logic [127:0] irq_req, cpu_irq;
	logic         awready, wready, bvalid, arready, rvalid, soft_irq, src_clr;
	logic         bus_req, bus_gnt, mem_valid, mem_write, mem_ack;
	logic [1:0]   bresp, rresp, mem_size;
	logic [23:0]  mem_addr;
	logic [6:0]   src_vec;
	logic [15:0]  vq [$];
	int           errors = 0;
	int           compares = 0;
	int           cyc = 0;
	xfe_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .irq_req_i(irq_req), .cpu_irq_o(cpu_irq),
		.soft_irq_o(soft_irq), .src_clr_o(src_clr), .src_clr_vec_o(src_vec),
		.bus_req_o(bus_req), .bus_gnt_i(bus_gnt), .mem_valid_o(mem_valid),
		.mem_write_o(mem_write), .mem_addr_o(mem_addr), .mem_size_o(mem_size),
		.mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
	xfe_mem_model mdl (.clk_i(clk_i), .resetn_i(resetn_i), .bus_req_i(bus_req),
		.bus_gnt_o(bus_gnt), .mem_valid_i(mem_valid), .mem_write_i(mem_write),
		.mem_addr_i(mem_addr), .mem_size_i(mem_size), .mem_wdata_i(mem_wdata),
		.mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		// The source withdraws a request once the engine has consumed it
		if (src_clr)
			irq_req[src_vec] <= 1'b0;
		if (mem_valid && mem_ack && !mem_write && mem_addr[23:8] == 16'h0004)
			vq.push_back(mem_addr[15:0]);
		if (cyc == 20000) begin
			errors++;
			close_out;
		end
	end
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		`CHK(rresp, er)
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		axr(a, d, er);
		`CHK(d, e)
	endtask
	task automatic idle;
		logic [31:0] d;
		do
			axr(`XFE_STATUS_OFS, d, 2'h0);
		while (d[0] !== 1'b0);
	endtask
	task automatic put(input logic [23:0] a, input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++)
			mdl.mem[a + i] = v[8 * (n - 1 - i) +: 8];
	endtask
	// Vector word unless v is 7F, then three longs of the descriptor in the on-chip page
	task automatic desc(input logic [6:0] v, input logic [15:0] a, input logic [31:0] l0, l1, l2);
		if (v != 7'h7F)
			put(24'h000400 + {v, 1'b0}, {16'h0, a}, 2);
		put({8'hFF, a}, l0, 4);
		put({8'hFF, a} + 24'h4, l1, 4);
		put({8'hFF, a} + 24'h8, l2, 4);
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, resetn_i} = 6'h0;
		{awaddr, araddr, wdata, irq_req} = 176'h0;
		repeat (20) @(posedge clk_i);
		resetn_i <= 1'b1;
		rreg(`XFE_CTRL_OFS, `XFE_CTRL_RESET, 2'h0);
		rreg(`XFE_EN0_OFS, `XFE_EN_RESET, 2'h0);
		rreg(8'h40, 32'h0, 2'h3);
		axw(8'h40, 32'hFFFF_FFFF, 2'h3);
		// Soft start, byte unit, both pointers increment, count not exhausted
		desc(7'h05, 16'hF800, {8'hA0, 24'h123400}, {8'h00, 24'hABCD00}, 32'h0002_0000);
		put(24'h123400, 32'h5A, 1);
		axw(`XFE_SOFT_VEC_OFS, 32'h85, 2'h0);
		idle;
		`CHK(mdl.rd(24'hABCD00, 1), 32'h5A)
		`CHK(mdl.rd(24'hFFF800, 4), {8'hA0, 24'h123401})
		`CHK(mdl.rd(24'hFFF804, 4), {8'h00, 24'hABCD01})
		`CHK(mdl.rd(24'hFFF808, 2), 32'h0001)
		`CHK(soft_irq, 1'b0)
		// Slow memory, word unit, source decrements, fixed destination, last unit
		mdl.wait_cyc = 2;
		desc(7'h06, 16'hF810, {8'hC1, 24'h123500}, {8'h00, 24'hABCE00}, 32'h0001_0000);
		put(24'h123500, 32'hBEEF, 2);
		axw(`XFE_SOFT_VEC_OFS, 32'h86, 2'h0);
		idle;
		`CHK(mdl.rd(24'hABCE00, 2), 32'hBEEF)
		`CHK(mdl.rd(24'hFFF810, 4), {8'hC1, 24'h1234FE})
		`CHK(mdl.rd(24'hFFF814, 4), {8'h00, 24'hABCE00})
		`CHK(soft_irq, 1'b1)
		axw(`XFE_SOFT_VEC_OFS, 32'h0, 2'h0);
		`CHK(soft_irq, 1'b0)
		// Stopped engine collects soft, vector 16, 17 and an unrouted 20
		mdl.wait_cyc = 0;
		axw(`XFE_CTRL_OFS, 32'h1, 2'h0);
		axw(`XFE_EN0_OFS, 32'h0003_0000, 2'h0);
		rreg(`XFE_EN0_OFS, 32'h0003_0000, 2'h0);
		desc(7'h07, 16'hF820, {8'h00, 24'h123600}, {8'h00, 24'hABCF00}, 32'h0005_0000);
		desc(7'h10, 16'hF830, {8'hA8, 24'h123700}, {8'h80, 24'hABD000}, 32'h0202_0001);
		desc(7'h7F, 16'hF83C, {8'h00, 24'h123710}, {8'h00, 24'hABD010}, 32'h0002_0000);
		desc(7'h11, 16'hF850, {8'h04, 24'h123800}, {8'h40, 24'hABD100}, 32'h0201_0000);
		put(24'h123600, 32'h55, 1);
		put(24'h123700, 32'h1122, 2);
		put(24'h123710, 32'h33, 1);
		put(24'h123800, 32'h44, 1);
		mdl.acks = 0;
		vq.delete();
		irq_req[16] <= 1'b1;
		irq_req[17] <= 1'b1;
		irq_req[20] <= 1'b1;
		axw(`XFE_SOFT_VEC_OFS, 32'h87, 2'h0);
		repeat (10) @(posedge clk_i);
		`CHK(bus_req, 1'b0)
		`CHK(cpu_irq[20], 1'b1)
		axw(`XFE_CTRL_OFS, 32'h0, 2'h0);
		while (mdl.acks < 37)
			@(posedge clk_i);
		idle;
		`CHK(vq.size(), 3)
		`CHK({vq[0], vq[1], vq[2]}, 48'h040E_0420_0422)
		`CHK(mdl.acks, 37)
		`CHK(mdl.rd(24'hABCF00, 1), 32'h55)
		`CHK(mdl.rd(24'hABD000, 2), 32'h1122)
		`CHK(mdl.rd(24'hFFF830, 4), {8'hA8, 24'h123702})
		`CHK(mdl.rd(24'hFFF834, 4), {8'h80, 24'hABD000})
		`CHK(mdl.rd(24'hFFF83A, 2), 32'h0000)
		`CHK(mdl.rd(24'hABD010, 1), 32'h33)
		`CHK(mdl.rd(24'hFFF844, 2), 32'h0001)
		`CHK(mdl.rd(24'hABD100, 1), 32'h44)
		`CHK(mdl.rd(24'hFFF858, 2), 32'h0202)
		@(posedge clk_i);
		`CHK(cpu_irq[17], 1'b1)
		irq_req <= 128'h0;
		repeat (2) @(posedge clk_i);
		close_out;
	end
endmodule
